// ===== pkg/mcpf_pkg.sv
// constants and types shared by the program-flow core and its data memory
package mcpf_pkg;
	// program counter and vectors
	localparam int PC_W = 11;
	localparam logic [10:0] VEC_RESET = 11'h000;
	localparam logic [10:0] VEC_EXT = 11'h004;
	localparam logic [10:0] VEC_TMR = 11'h008;
	localparam logic [10:0] VEC_ADC = 11'h00C;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam logic [2:0] LAST_PAGE = 3'h7;
	// return stack
	localparam int STK_DEPTH = 6;
	// data memory map
	localparam logic [6:0] ADDR_IND = 7'h00;
	localparam logic [6:0] ADDR_MP = 7'h01;
	localparam logic [6:0] ADDR_LOOKUP_POINTER = 7'h07;
	localparam logic [6:0] ADDR_LOOKUP_HIGH_LATCH = 7'h08;
	localparam logic [6:0] ADDR_STATUS = 7'h0A;
	localparam logic [6:0] RAM_LO = 7'h28;
	localparam logic [6:0] RAM_HI = 7'h7F;
	localparam int RAM_DEPTH = 88;
	localparam logic [7:0] RD_ZERO = 8'h00;
	// flag register layout
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_PDF = 4;
	localparam int FLAG_TO = 5;
	// interrupt sources, highest priority first
	localparam int SRC_EXT = 0;
	localparam int SRC_TMR = 1;
	localparam int SRC_ADC = 2;
	// decoded instructions
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_AND = 5'h03,
		OP_OR = 5'h04, OP_XOR = 5'h05, OP_INC = 5'h06, OP_DEC = 5'h07,
		OP_RLC = 5'h08, OP_RRC = 5'h09, OP_BSET = 5'h0A, OP_BCLR = 5'h0B,
		OP_MOVW = 5'h0C, OP_MOVR = 5'h0D, OP_TRDC = 5'h0E, OP_TRDL = 5'h0F,
		OP_CALL = 5'h10, OP_JMP = 5'h11, OP_RET = 5'h12, OP_IRQ_EXIT = 5'h13,
		OP_WDTCLR = 5'h14, OP_HALT = 5'h15, OP_IRQ = 5'h16
	} mcpf_op_t;
	// execution sequence
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_D1 = 3'b001, ST_D2 = 3'b010, ST_RD = 3'b011, ST_WB = 3'b100
	} mcpf_state_t;
endpackage

// ===== hdl/mcpf_ram.sv
// general-purpose data memory with registered read data
`timescale 1ns/10ps
module mcpf_ram #(
	parameter int AW = 7,
	parameter int DW = 8,
	parameter int DEPTH = mcpf_pkg::RAM_DEPTH,
	parameter logic [6:0] BASE = mcpf_pkg::RAM_LO
)(
	// clock
	input wire logic core_clk,
	// write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read side
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [DEPTH];
	logic [AW-1:0] widx;
	logic [AW-1:0] ridx;

	// window is based at BASE; the caller only enables writes inside it
	assign widx = AW'(waddr - BASE);
	assign ridx = AW'(raddr - BASE);

	// one write and one registered read each cycle
	always_ff @(posedge core_clk)
	begin
		if (we && widx < AW'(DEPTH))
			mem[widx] <= wdata;
		rdata_q <= (ridx < AW'(DEPTH)) ? mem[ridx] : '0;
	end
endmodule

// ===== hdl/mcpf_core.sv
// program-flow, table-read, return-stack and data-access logic of the 8-bit core
// Overview of operation
// [R1] reset loads program counter with 000H
// [R2] enabled external falling edge vectors to 004H
// [R3] enabled timer overflow vectors to 008H
// [R4] enabled conversion complete vectors to 00CH
// [R5] table address: page bits above pointer
// [R6] low byte to memory, rest to latch
// [R7] pointer read/write, high latch read-only
// [R8] table reads take two instruction cycles
// [R9] six-entry stack, invisible to software
// [R10] call/interrupt push PC, returns pop it
// [R11] reset leaves the stack empty
// [R12] full stack holds off interrupt acknowledge
// [R13] call on full stack drops oldest
// [R14] reserved data locations read 00H
// [R15] general memory 28H-7FH, directly operable
// [R16] any data bit can be set/cleared
// [R17] location 00H accesses via indirect pointer
// [R18] seven-bit pointer, bit 7 reads one
// [R19] flag writes leave timeout/halted untouched
// [R20] timeout/halted flags change only by events
// [R21] arithmetic flags follow latest operation
// [R22] flags never stacked automatically
// [R23] flags C,AC,Z,OV at bits 0-3
// [R24] halted bit 4, timeout bit 5
// [R25] global gate and source enable required
`timescale 1ns/10ps
module mcpf_core #(
	parameter int STK_DEPTH = mcpf_pkg::STK_DEPTH
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// decoded instruction issue
	input wire logic instr_valid,
	output logic instr_ready,
	input wire mcpf_pkg::mcpf_op_t instr_op,
	input wire logic [6:0] instr_addr,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_acc,
	input wire logic instr_to_mem,
	input wire logic [10:0] instr_target,
	// execution results
	output logic [7:0] result_q,
	output logic [10:0] pc_q,
	output logic [7:0] status_flags,
	output logic [7:0] lookup_high_latch,
	output logic stack_full,
	// program memory table port, one cycle latency
	output logic [10:0] pmem_addr_q,
	input wire logic [14:0] pmem_rdata,
	// interrupt sources and enables
	input wire logic ext_irq_n_pin,
	input wire logic timer_ovf,
	input wire logic adc_done,
	input wire logic global_irq_gate,
	input wire logic ext_irq_en,
	input wire logic tmr_irq_en,
	input wire logic adc_irq_en,
	output logic [2:0] irq_pending,
	output logic [2:0] irq_ack,
	output logic irq_exit,
	// watchdog
	input wire logic wdt_timeout
);
	localparam int SPW = $clog2(STK_DEPTH);

	mcpf_pkg::mcpf_state_t state_q;
	mcpf_pkg::mcpf_op_t op_q;
	logic [6:0] addr_q;
	logic null_q;
	logic [2:0] bit_q;
	logic [7:0] acc_q;
	logic to_mem_q;
	logic [10:0] target_q;
	logic [10:0] vec_q;
	logic [14:0] tword_q;
	logic [6:0] mp_q;
	logic [7:0] lookup_pointer_q;
	logic [7:0] lookup_high_latch_q;
	logic [3:0] arith_q;
	logic pdf_q;
	logic to_q;
	logic [2:0] pend_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	logic [10:0] stk_q [STK_DEPTH];
	logic [SPW-1:0] sp_q;
	logic [SPW:0] cnt_q;
	logic [7:0] ram_rdata;
	logic [2:0] src_evt, src_en, src_req, src_sel;
	logic irq_take, take, wb, long_op, is_tbl, mem_wr;
	logic push, pop;
	logic [SPW-1:0] top_idx, sp_up;
	logic [6:0] ea;
	logic [7:0] m, res, wdata;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [3:0] arith_n;
	logic flag_upd;

	// the pin is asynchronous: two flops before the edge detector reads it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
			ext_s3_q <= 1'b1;
		end
		else
		begin
			ext_s1_q <= ext_irq_n_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign src_evt = {adc_done, timer_ovf, ext_s3_q & ~ext_s2_q}; // [R2] [R3] [R4]
	assign src_en = {adc_irq_en, tmr_irq_en, ext_irq_en};
	assign src_req = pend_q & src_en & {3{global_irq_gate}}; // [R25]
	// fixed priority: external, then timer, then converter
	assign src_sel = src_req[0] ? 3'b001 : src_req[1] ? 3'b010 : src_req[2] ? 3'b100 : 3'b000;
	// a full stack leaves the request flag pending until a return frees a level
	assign irq_take = (state_q == mcpf_pkg::ST_IDLE) && (|src_req) && !stack_full; // [R12]
	assign irq_ack = irq_take ? src_sel : 3'b000;
	assign irq_pending = pend_q;
	assign instr_ready = (state_q == mcpf_pkg::ST_IDLE) && !irq_take;
	assign take = instr_valid && instr_ready;
	assign wb = (state_q == mcpf_pkg::ST_WB);
	assign irq_exit = wb && (op_q == mcpf_pkg::OP_IRQ_EXIT);

	// request flags: an event in the clearing cycle still sets its flag
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pend
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					pend_q[gi] <= 1'b0;
				else if (src_evt[gi])
					pend_q[gi] <= 1'b1; // [R12]
				else if (irq_ack[gi])
					pend_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// address 00H redirects through the pointer; pointer value 00H is a null target
	assign ea = (instr_addr == mcpf_pkg::ADDR_IND) ? mp_q : instr_addr; // [R17]
	assign long_op = instr_op inside {mcpf_pkg::OP_TRDC, mcpf_pkg::OP_TRDL, mcpf_pkg::OP_CALL,
		mcpf_pkg::OP_JMP, mcpf_pkg::OP_RET, mcpf_pkg::OP_IRQ_EXIT};
	assign is_tbl = (op_q == mcpf_pkg::OP_TRDC) || (op_q == mcpf_pkg::OP_TRDL);

	// sequence: short ops RD,WB; table reads and transfers add D1,D2
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state_q <= mcpf_pkg::ST_IDLE;
		else
		begin
			unique case (state_q)
				mcpf_pkg::ST_IDLE:
				begin
					if (irq_take)
						state_q <= mcpf_pkg::ST_D1;
					else if (take)
						state_q <= long_op ? mcpf_pkg::ST_D1 : mcpf_pkg::ST_RD; // [R8]
				end
				mcpf_pkg::ST_D1: state_q <= mcpf_pkg::ST_D2;
				mcpf_pkg::ST_D2: state_q <= mcpf_pkg::ST_RD;
				mcpf_pkg::ST_RD: state_q <= mcpf_pkg::ST_WB;
				mcpf_pkg::ST_WB: state_q <= mcpf_pkg::ST_IDLE;
				default: state_q <= mcpf_pkg::ST_IDLE;
			endcase
		end
	end

	// operands latched when an instruction or interrupt is taken
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_q <= mcpf_pkg::OP_NOP;
			addr_q <= 7'h00;
			null_q <= 1'b0;
			bit_q <= 3'h0;
			acc_q <= 8'h00;
			to_mem_q <= 1'b0;
			target_q <= 11'h000;
			vec_q <= mcpf_pkg::VEC_RESET;
		end
		else if (irq_take)
		begin
			op_q <= mcpf_pkg::OP_IRQ;
			null_q <= 1'b1;
			vec_q <= src_sel[0] ? mcpf_pkg::VEC_EXT : src_sel[1] ? mcpf_pkg::VEC_TMR : mcpf_pkg::VEC_ADC;
		end
		else if (take)
		begin
			op_q <= instr_op;
			addr_q <= ea;
			null_q <= (ea == mcpf_pkg::ADDR_IND); // [R17]
			bit_q <= instr_bit;
			acc_q <= instr_acc;
			to_mem_q <= instr_to_mem;
			target_q <= instr_target;
		end
	end

	// table word fetch: page from PC or the last page, pointer below it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pmem_addr_q <= 11'h000;
			tword_q <= 15'h0000;
		end
		else
		begin
			if (state_q == mcpf_pkg::ST_D1 && is_tbl)
				pmem_addr_q <= {(op_q == mcpf_pkg::OP_TRDL) ? mcpf_pkg::LAST_PAGE : pc_q[10:8], lookup_pointer_q}; // [R5]
			if (state_q == mcpf_pkg::ST_D2 && is_tbl)
				tword_q <= pmem_rdata;
		end
	end

	mcpf_ram u_ram (
		.core_clk(core_clk),
		.we(mem_wr && addr_q >= mcpf_pkg::RAM_LO),
		.waddr(addr_q),
		.wdata(wdata),
		.raddr(addr_q),
		.rdata_q(ram_rdata)
	);

	// operand read; unused and reserved locations return 00H
	always_comb
	begin
		m = mcpf_pkg::RD_ZERO; // [R14]
		if (null_q)
			m = mcpf_pkg::RD_ZERO; // [R17]
		else if (addr_q >= mcpf_pkg::RAM_LO)
			m = ram_rdata; // [R15]
		else if (addr_q == mcpf_pkg::ADDR_MP)
			m = {1'b1, mp_q}; // [R18]
		else if (addr_q == mcpf_pkg::ADDR_LOOKUP_POINTER)
			m = lookup_pointer_q;
		else if (addr_q == mcpf_pkg::ADDR_LOOKUP_HIGH_LATCH)
			m = lookup_high_latch_q;
		else if (addr_q == mcpf_pkg::ADDR_STATUS)
			m = status_flags;
	end

	// arithmetic and logic on the operand, with the new flag values
	always_comb
	begin
		sum9 = 9'h000;
		nib5 = 5'h00;
		res = m;
		arith_n = arith_q;
		flag_upd = 1'b0;
		case (op_q)
			mcpf_pkg::OP_ADD:
			begin
				sum9 = {1'b0, acc_q} + {1'b0, m};
				nib5 = {1'b0, acc_q[3:0]} + {1'b0, m[3:0]};
				res = sum9[7:0];
				arith_n[mcpf_pkg::FLAG_C] = sum9[8];
				arith_n[mcpf_pkg::FLAG_AC] = nib5[4];
				arith_n[mcpf_pkg::FLAG_OV] = (acc_q[7] == m[7]) && (sum9[7] != acc_q[7]);
			end
			mcpf_pkg::OP_SUB:
			begin
				sum9 = {1'b0, acc_q} - {1'b0, m};
				res = sum9[7:0];
				arith_n[mcpf_pkg::FLAG_C] = ~sum9[8];
				arith_n[mcpf_pkg::FLAG_AC] = (acc_q[3:0] >= m[3:0]);
				arith_n[mcpf_pkg::FLAG_OV] = (acc_q[7] != m[7]) && (sum9[7] != acc_q[7]);
			end
			mcpf_pkg::OP_AND: res = acc_q & m;
			mcpf_pkg::OP_OR: res = acc_q | m;
			mcpf_pkg::OP_XOR: res = acc_q ^ m;
			mcpf_pkg::OP_INC: res = m + 8'h01;
			mcpf_pkg::OP_DEC: res = m - 8'h01;
			mcpf_pkg::OP_RLC:
			begin
				res = {m[6:0], arith_q[mcpf_pkg::FLAG_C]};
				arith_n[mcpf_pkg::FLAG_C] = m[7];
			end
			mcpf_pkg::OP_RRC:
			begin
				res = {arith_q[mcpf_pkg::FLAG_C], m[7:1]};
				arith_n[mcpf_pkg::FLAG_C] = m[0];
			end
			mcpf_pkg::OP_BSET: res = m | (8'h01 << bit_q); // [R16]
			mcpf_pkg::OP_BCLR: res = m & ~(8'h01 << bit_q); // [R16]
			mcpf_pkg::OP_MOVW: res = acc_q;
			default: res = m;
		endcase
		if (op_q inside {mcpf_pkg::OP_ADD, mcpf_pkg::OP_SUB, mcpf_pkg::OP_AND, mcpf_pkg::OP_OR,
			mcpf_pkg::OP_XOR, mcpf_pkg::OP_INC, mcpf_pkg::OP_DEC, mcpf_pkg::OP_RLC, mcpf_pkg::OP_RRC})
		begin
			flag_upd = 1'b1;
			arith_n[mcpf_pkg::FLAG_Z] = (res == 8'h00); // [R23]
		end
	end

	// write-back: the null target swallows writes
	assign wdata = is_tbl ? tword_q[7:0] : res; // [R6]
	assign mem_wr = wb && !null_q && (is_tbl || op_q == mcpf_pkg::OP_MOVW || op_q == mcpf_pkg::OP_BSET
		|| op_q == mcpf_pkg::OP_BCLR || (to_mem_q && flag_upd));

	// pointer registers; the high latch ignores software writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mp_q <= 7'h00;
			lookup_pointer_q <= 8'h00;
			lookup_high_latch_q <= 8'h00;
		end
		else
		begin
			if (mem_wr && addr_q == mcpf_pkg::ADDR_MP)
				mp_q <= wdata[6:0]; // [R18]
			if (mem_wr && addr_q == mcpf_pkg::ADDR_LOOKUP_POINTER)
				lookup_pointer_q <= wdata; // [R7]
			if (wb && is_tbl)
				lookup_high_latch_q <= {1'b0, tword_q[14:8]}; // [R6]
		end
	end

	// arithmetic flags: a direct write first, the operation's own flags win
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			arith_q <= 4'h0;
		else
		begin
			if (mem_wr && addr_q == mcpf_pkg::ADDR_STATUS)
				arith_q <= wdata[3:0]; // [R19]
			if (wb && flag_upd)
				arith_q <= arith_n; // [R21]
		end
	end

	// halted and timeout flags move only on their events; time-out wins a tie
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pdf_q <= 1'b0;
			to_q <= 1'b0;
		end
		else
		begin
			if (wb && op_q == mcpf_pkg::OP_HALT)
			begin
				pdf_q <= 1'b1; // [R24]
				to_q <= 1'b0;
			end
			if (wb && op_q == mcpf_pkg::OP_WDTCLR)
			begin
				pdf_q <= 1'b0; // [R20]
				to_q <= 1'b0;
			end
			if (wdt_timeout)
				to_q <= 1'b1; // [R24]
		end
	end

	assign status_flags = {2'b00, to_q, pdf_q, arith_q}; // [R23]
	assign lookup_high_latch = lookup_high_latch_q;

	// return stack: a ring with no software path, so overflow overwrites the oldest
	assign push = wb && (op_q == mcpf_pkg::OP_CALL || op_q == mcpf_pkg::OP_IRQ); // [R10] [R22]
	assign pop = wb && (op_q == mcpf_pkg::OP_RET || op_q == mcpf_pkg::OP_IRQ_EXIT);
	assign sp_up = (sp_q == SPW'(STK_DEPTH - 1)) ? '0 : sp_q + 1'b1;
	assign top_idx = (sp_q == '0) ? SPW'(STK_DEPTH - 1) : sp_q - 1'b1;
	assign stack_full = (cnt_q == (SPW + 1)'(STK_DEPTH));

	generate
		for (gi = 0; gi < STK_DEPTH; gi++)
		begin : g_stk
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					stk_q[gi] <= 11'h000;
				else if (push && sp_q == SPW'(gi))
					stk_q[gi] <= (op_q == mcpf_pkg::OP_IRQ) ? pc_q : pc_q + mcpf_pkg::PC_STEP; // [R9]
			end
		end
	endgenerate

	// level count saturates at the depth; reset empties the stack
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sp_q <= '0; // [R11]
			cnt_q <= '0;
		end
		else if (push)
		begin
			sp_q <= sp_up;
			if (!stack_full)
				cnt_q <= cnt_q + 1'b1; // [R13]
		end
		else if (pop)
		begin
			sp_q <= top_idx;
			if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// program counter updates at write-back
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pc_q <= mcpf_pkg::VEC_RESET; // [R1]
		else if (wb)
		begin
			unique case (op_q)
				mcpf_pkg::OP_IRQ: pc_q <= vec_q; // [R2] [R3] [R4]
				mcpf_pkg::OP_CALL, mcpf_pkg::OP_JMP: pc_q <= target_q;
				mcpf_pkg::OP_RET, mcpf_pkg::OP_IRQ_EXIT: pc_q <= stk_q[top_idx]; // [R10]
				default: pc_q <= pc_q + mcpf_pkg::PC_STEP;
			endcase
		end
	end

	// result towards the accumulator
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			result_q <= 8'h00;
		else if (wb && (flag_upd || op_q == mcpf_pkg::OP_MOVR))
			result_q <= res;
	end

	// checks
	logic wb_seen_q;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			wb_seen_q <= 1'b0;
		else if (wb)
			wb_seen_q <= 1'b1;
	end

	a_reset_pc: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
		!wb_seen_q |-> pc_q == mcpf_pkg::VEC_RESET) else $error("pc not at reset vector");
	a_ext_vector: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
		irq_ack[0] |-> ##5 pc_q == mcpf_pkg::VEC_EXT) else $error("external vector missed");
	a_tmr_vector: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
		irq_ack[1] |-> ##5 pc_q == mcpf_pkg::VEC_TMR) else $error("timer vector missed");
	a_adc_vector: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
		irq_ack[2] |-> ##5 pc_q == mcpf_pkg::VEC_ADC) else $error("converter vector missed");
	a_full_holds: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
		stack_full |-> irq_ack == 3'b000) else $error("acknowledge with full stack");
	a_table_time: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
		take && (instr_op == mcpf_pkg::OP_TRDC || instr_op == mcpf_pkg::OP_TRDL)
		|-> ##1 (state_q != mcpf_pkg::ST_IDLE)[*4] ##1 state_q == mcpf_pkg::ST_IDLE)
		else $error("table read length wrong");
	a_latch_source: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
		$changed(lookup_high_latch_q) |-> $past(wb && is_tbl) && lookup_high_latch_q[7] == 1'b0) else $error("latch changed outside table read");
	a_ret_pop: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
		pop |=> pc_q == $past(stk_q[top_idx])) else $error("return address wrong");
	a_full_keep: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
		push && stack_full |=> stack_full && sp_q == $past(sp_up)) else $error("overflow handling wrong");
	a_pdf_guard: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
		$changed(pdf_q) |-> $past(wb && (op_q == mcpf_pkg::OP_HALT || op_q == mcpf_pkg::OP_WDTCLR)))
		else $error("halted flag changed without cause");
	a_zero_flag: assert property (@(posedge core_clk) disable iff (!resetn) // [R21]
		wb && flag_upd |=> status_flags[mcpf_pkg::FLAG_Z] == ($past(res) == 8'h00)) else $error("zero flag wrong");

	c_irq_taken: cover property (@(posedge core_clk) disable iff (!resetn) irq_take ##5 state_q == mcpf_pkg::ST_IDLE);
	c_table_read: cover property (@(posedge core_clk) disable iff (!resetn) wb && is_tbl && !null_q);
	c_call_full: cover property (@(posedge core_clk) disable iff (!resetn) push && stack_full);
endmodule

// ===== tb/tb_mcu_core_program_flow.sv
// self-checking bench for the program-flow core, driven through its instruction port
`timescale 1ns/10ps
module tb_mcu_core_program_flow;
	logic core_clk, resetn, instr_valid, instr_ready, instr_to_mem, stack_full, irq_exit;
	logic ext_irq_n_pin, timer_ovf, adc_done, global_irq_gate, ext_irq_en, tmr_irq_en, adc_irq_en, wdt_timeout;
	mcpf_pkg::mcpf_op_t instr_op;
	logic [6:0] instr_addr;
	logic [2:0] instr_bit, irq_pending, irq_ack, ack_last;
	logic [7:0] instr_acc, result_q, status_flags, lookup_high_latch;
	logic [10:0] instr_target, pc_q, pmem_addr_q;
	logic [14:0] pmem_rdata;
	int mismatches, total_checks, cyc, n_cycles;

	mcpf_core u_dut (
		.core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_ready(instr_ready),
		.instr_op(instr_op), .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_acc(instr_acc),
		.instr_to_mem(instr_to_mem), .instr_target(instr_target), .result_q(result_q), .pc_q(pc_q),
		.status_flags(status_flags), .lookup_high_latch(lookup_high_latch), .stack_full(stack_full),
		.pmem_addr_q(pmem_addr_q), .pmem_rdata(pmem_rdata), .ext_irq_n_pin(ext_irq_n_pin),
		.timer_ovf(timer_ovf), .adc_done(adc_done), .global_irq_gate(global_irq_gate),
		.ext_irq_en(ext_irq_en), .tmr_irq_en(tmr_irq_en), .adc_irq_en(adc_irq_en),
		.irq_pending(irq_pending), .irq_ack(irq_ack), .irq_exit(irq_exit), .wdt_timeout(wdt_timeout)
	);

	// program memory word: the high bits differ from the address so the latch content is traceable
	assign pmem_rdata = {~pmem_addr_q[10:4], pmem_addr_q[7:0]};

	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// interrupt controller stand-in: ack closes the gate, irq exit reopens it
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			global_irq_gate <= 1'b1;
		else if (|irq_ack)
			global_irq_gate <= 1'b0;
		else if (irq_exit)
			global_irq_gate <= 1'b1;
	end

	// remember the last source taken, since the ack pulse lasts one cycle
	always @(negedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ack_last = 3'h0;
		else if (|irq_ack)
			ack_last = irq_ack;
	end

	// hang guard, well above the few hundred cycles the sequence needs
	always @(posedge core_clk)
	begin
		n_cycles++;
		if (n_cycles == 5000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_pc(input logic [10:0] g, input logic [10:0] e);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// counts low-ready cycles until the port is free again; bounded so a stuck core is reported
	task automatic wait_ready();
		cyc = 0;
		forever
		begin
			@(negedge core_clk);
			if (instr_ready === 1'b1)
				break;
			cyc++;
			if (cyc > 60)
			begin
				mismatches++;
				$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
				tally_and_finish();
			end
		end
	endtask

	// offer one instruction, hold it until taken, then wait for completion
	task automatic issue(input mcpf_pkg::mcpf_op_t op, input logic [6:0] a, input logic [7:0] v,
		input logic [2:0] b, input logic tm, input logic [10:0] t);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_addr <= a;
		instr_acc <= v;
		instr_bit <= b;
		instr_to_mem <= tm;
		instr_target <= t;
		wait_ready();
		@(posedge core_clk);
		instr_valid <= 1'b0;
		wait_ready();
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		issue(mcpf_pkg::OP_MOVW, a, v, 3'h0, 1'b0, 11'h000);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		issue(mcpf_pkg::OP_MOVR, a, 8'h00, 3'h0, 1'b0, 11'h000);
		chk_data(result_q, e);
	endtask

	task automatic op(input mcpf_pkg::mcpf_op_t o, input logic [6:0] a, input logic [2:0] b, input logic [10:0] t);
		issue(o, a, 8'h00, b, 1'b0, t);
	endtask

	task automatic alu(input mcpf_pkg::mcpf_op_t o, input logic [6:0] a, input logic [7:0] v, input logic tm,
		input logic [7:0] res, input logic [7:0] fl);
		issue(o, a, v, 3'h0, tm, 11'h000);
		chk_data(result_q, res);
		chk_data(status_flags, fl);
	endtask

	// main sequence
	initial
	begin
		resetn = 1'b0;
		instr_valid = 1'b0;
		instr_op = mcpf_pkg::OP_NOP;
		instr_addr = 7'h00;
		instr_bit = 3'h0;
		instr_acc = 8'h00;
		instr_to_mem = 1'b0;
		instr_target = 11'h000;
		ext_irq_n_pin = 1'b1;
		timer_ovf = 1'b0;
		adc_done = 1'b0;
		ext_irq_en = 1'b1;
		tmr_irq_en = 1'b1;
		adc_irq_en = 1'b0;
		wdt_timeout = 1'b0;
		mismatches = 0;
		total_checks = 0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		chk_pc(pc_q, mcpf_pkg::VEC_RESET);
		chk_data({7'h00, stack_full}, 8'h00);
		// data map: ends of general memory, a reserved hole, indirect access
		wr(7'h28, 8'hFF);
		wr(7'h29, 8'h40);
		rd(7'h29, 8'h40);
		wr(7'h20, 8'h77);
		rd(7'h20, 8'h00);
		wr(7'h7F, 8'h3C);
		wr(7'h01, 8'h30);
		rd(7'h01, 8'hB0);
		wr(7'h00, 8'h5A);
		rd(7'h30, 8'h5A);
		wr(7'h01, 8'h00);
		rd(7'h00, 8'h00);
		// flags follow the latest operation; logic ops touch only zero
		alu(mcpf_pkg::OP_ADD, 7'h28, 8'h01, 1'b0, 8'h00, 8'h07);
		alu(mcpf_pkg::OP_ADD, 7'h29, 8'h40, 1'b0, 8'h80, 8'h08);
		alu(mcpf_pkg::OP_AND, 7'h29, 8'h0F, 1'b0, 8'h00, 8'h0C);
		alu(mcpf_pkg::OP_ADD, 7'h7F, 8'h01, 1'b1, 8'h3D, 8'h00);
		rd(7'h7F, 8'h3D);
		// seventeen single-step instructions since reset
		chk_pc(pc_q, 11'h011);
		chk_data(8'(cyc), 8'h02);
		// software flag writes against the event-driven flags
		wr(7'h0A, 8'hFF);
		chk_data(status_flags, 8'h0F);
		@(posedge core_clk);
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		@(negedge core_clk);
		chk_data(status_flags, 8'h2F);
		wr(7'h0A, 8'h00);
		chk_data(status_flags, 8'h20);
		op(mcpf_pkg::OP_HALT, 7'h00, 3'h0, 11'h000);
		chk_data(status_flags, 8'h10);
		op(mcpf_pkg::OP_WDTCLR, 7'h00, 3'h0, 11'h000);
		chk_data(status_flags, 8'h00);
		op(mcpf_pkg::OP_BCLR, 7'h28, 3'h6, 11'h000);
		rd(7'h28, 8'hBF);
		op(mcpf_pkg::OP_BSET, 7'h28, 3'h6, 11'h000);
		rd(7'h28, 8'hFF);
		// table reads from a non-zero page and from the last page
		op(mcpf_pkg::OP_JMP, 7'h00, 3'h0, 11'h523);
		wr(7'h07, 8'h34);
		rd(7'h07, 8'h34);
		op(mcpf_pkg::OP_TRDC, 7'h2A, 3'h0, 11'h000);
		chk_data(8'(cyc), 8'h04);
		chk_pc(pmem_addr_q, 11'h534);
		chk_data(lookup_high_latch, 8'h2C);
		rd(7'h2A, 8'h34);
		op(mcpf_pkg::OP_TRDL, 7'h2B, 3'h0, 11'h000);
		chk_pc(pmem_addr_q, 11'h734);
		chk_data(lookup_high_latch, 8'h0C);
		wr(7'h08, 8'hFF);
		chk_data(lookup_high_latch, 8'h0C);
		// seven nested calls: the oldest return address falls out
		wr(7'h0A, 8'h05);
		op(mcpf_pkg::OP_JMP, 7'h00, 3'h0, 11'h100);
		for (int i = 0; i < 7; i++)
			op(mcpf_pkg::OP_CALL, 7'h00, 3'h0, 11'h200 + 11'(i * 16));
		chk_pc(pc_q, 11'h260);
		chk_data({7'h00, stack_full}, 8'h01);
		// timer request on a full stack waits for a return
		@(posedge core_clk);
		timer_ovf <= 1'b1;
		@(posedge core_clk);
		timer_ovf <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk_data({5'h00, irq_pending}, 8'h02);
		chk_pc(pc_q, 11'h260);
		op(mcpf_pkg::OP_RET, 7'h00, 3'h0, 11'h000);
		chk_pc(pc_q, mcpf_pkg::VEC_TMR);
		chk_data({5'h00, ack_last}, 8'h02);
		wr(7'h0A, 8'h0A);
		// external edge while the gate is closed stays pending until the irq exit
		@(posedge core_clk);
		ext_irq_n_pin <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk_data({5'h00, irq_pending}, 8'h01);
		@(posedge core_clk);
		ext_irq_n_pin <= 1'b1;
		op(mcpf_pkg::OP_IRQ_EXIT, 7'h00, 3'h0, 11'h000);
		chk_pc(pc_q, mcpf_pkg::VEC_EXT);
		chk_data({5'h00, ack_last}, 8'h01);
		op(mcpf_pkg::OP_IRQ_EXIT, 7'h00, 3'h0, 11'h000);
		chk_pc(pc_q, 11'h251);
		chk_data(status_flags, 8'h0A);
		// conversion request held off by its own enable
		@(posedge core_clk);
		adc_done <= 1'b1;
		@(posedge core_clk);
		adc_done <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk_data({5'h00, irq_pending}, 8'h04);
		@(posedge core_clk);
		adc_irq_en <= 1'b1;
		repeat (2) @(negedge core_clk);
		wait_ready();
		chk_pc(pc_q, mcpf_pkg::VEC_ADC);
		chk_data({5'h00, ack_last}, 8'h04);
		op(mcpf_pkg::OP_IRQ_EXIT, 7'h00, 3'h0, 11'h000);
		chk_pc(pc_q, 11'h251);
		// unwind what is left: the five surviving call return addresses, newest first
		for (int k = 0; k < 5; k++)
		begin
			op(mcpf_pkg::OP_RET, 7'h00, 3'h0, 11'h000);
			chk_pc(pc_q, 11'h241 - 11'(k * 16));
		end
		chk_data({7'h00, stack_full}, 8'h00);
		tally_and_finish();
	end
endmodule
